/* verilog/buck_seq_defs.vh */
// Offsets, field positions, reset values and timing constants of the buck sequencer.
`ifndef BUCK_SEQ_DEFS_VH
`define BUCK_SEQ_DEFS_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define REG_CTRL 8'h00
`define REG_OPER 8'h04
`define REG_RISE 8'h08
`define REG_FALL 8'h0C
`define REG_TARGET 8'h10
`define REG_OC_FLT 8'h14
`define REG_OC_WRN 8'h18
`define REG_OC_RESP 8'h1C
`define REG_TRIM 8'h20
`define REG_OPTIONS 8'h24
`define REG_STATUS 8'h28
`define REG_IOUT 8'h2C
`define REG_MASK 8'h30
// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define CTRL_SOFTSTOP_BIT 0
`define OPER_ON_BIT 6
`define OPT_NEGDIS_BIT 0
`define RESP_LATCH 2'h0
`define RESP_HICCUP 2'h1
`define ST_OCF_BIT 0
`define ST_OCW_BIT 1
`define ST_OVW_BIT 2
`define ST_SHARE_BIT 3
`define ST_NEG_BIT 4
`define RST_CTRL 1'h1
`define RST_OPER 8'h80
`define RST_RISE 3'h0
`define RST_FALL 3'h0
`define RST_TARGET 12'h133
`define RST_OC_FLT 12'hC00
`define RST_OC_WRN 12'hA00
`define RST_RESP 2'h0
`define RST_MASK 1'h0
// ----------------------------------------
// Timing and thresholds
// ----------------------------------------
`define CLK_MHZ 200
`define UNIT_MS 1
`define MIN_OFF_NS 150
`define OC_CONSEC 3
`define PB_PULSES 128
`define HICCUP_RISES 7
`define OVW_NUM 21
`define OVW_DEN 20
`endif

/* verilog/buck_seq.v */
// Soft-start, soft-stop, current telemetry and overcurrent sequencer of a buck converter.
// ----------------------------------------
// ----------------------------------------
`timescale 1ns/1ps
`include "buck_seq_defs.vh"
module buck_seq #(
  parameter MS_CYCLES = `UNIT_MS * 1000 * `CLK_MHZ,
  parameter PERIOD = 400
) (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire control_pin,
  input wire shared_loop_line_i,
  output reg shared_loop_line_o,
  output reg shared_loop_line_oe,
  input wire hs_limit_cmp,
  input wire neg_limit_cmp,
  input wire ov_cmp,
  input wire [11:0] feedback_input,
  input wire [11:0] isense_code,
  input wire [9:0] duty_code,
  output reg [11:0] ref_code,
  output reg hs_gate,
  output reg ls_gate,
  output reg ov_warning,
  output reg alert_n
);
  localparam S_OFF = 3'd0;
  localparam S_SS = 3'd1;
  localparam S_RUN = 3'd2;
  localparam S_STOP = 3'd3;
  localparam S_HIC = 3'd4;
  localparam S_LATCH = 3'd5;
  localparam [9:0] MIN_OFF = (`MIN_OFF_NS * `CLK_MHZ + 999) / 1000;
  localparam [9:0] LAST = PERIOD - 1;
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  wire [4:0] pin_raw;
  wire [4:0] pin_q;
  assign pin_raw = {ov_cmp, neg_limit_cmp, hs_limit_cmp, shared_loop_line_i, control_pin};
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_sync
      reg s1_q, s2_q, s3_q, out_q;
      always @(posedge aclk) begin
        s1_q <= pin_raw[gi];
        s2_q <= s1_q;
        s3_q <= s2_q;
        if (!aresetn) begin
          out_q <= (gi == 1) ? 1'b1 : 1'b0;
        end else if (s2_q == s3_q) begin
          out_q <= s3_q;
        end
      end
      assign pin_q[gi] = out_q;
    end
  endgenerate
  wire ctl_s, share_s, hsl_s, neg_s, ov_s;
  assign {ov_s, neg_s, hsl_s, share_s, ctl_s} = pin_q;
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg ctrl_q, negdis_q, mask_q;
  reg [7:0] oper_q;
  reg [2:0] rise_q, fall_q, state_q;
  reg [11:0] target_q, ocf_q, ocw_q, trim_q;
  reg [1:0] resp_q;
  reg [4:0] sticky_q;
  reg [14:0] avg_q;
  wire [4:0] ev;
  wire wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  wire [4:0] w1c = (wr_go && s_axi_awaddr == `REG_STATUS) ? s_axi_wdata[4:0] : 5'h00;
  function wr_ok;
    input [7:0] a;
    begin
      wr_ok = (a <= `REG_MASK) && (a[1:0] == 2'h0) && (a != `REG_IOUT);
    end
  endfunction
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      ctrl_q <= `RST_CTRL;
      oper_q <= `RST_OPER;
      rise_q <= `RST_RISE;
      fall_q <= `RST_FALL;
      target_q <= `RST_TARGET;
      ocf_q <= `RST_OC_FLT;
      ocw_q <= `RST_OC_WRN;
      resp_q <= `RST_RESP;
      trim_q <= 12'h000;
      negdis_q <= 1'b0;
      mask_q <= `RST_MASK;
      sticky_q <= 5'h00;
    end else begin
      s_axi_awready <= wr_go;
      s_axi_wready <= wr_go;
      // A clear that meets a new event in the same cycle loses to the event.
      sticky_q <= (sticky_q & ~w1c) | ev;
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok(s_axi_awaddr) ? 2'h0 : 2'h2;
        if (s_axi_wstrb[0]) begin
          case (s_axi_awaddr)
            `REG_CTRL: ctrl_q <= s_axi_wdata[`CTRL_SOFTSTOP_BIT];
            `REG_OPER: oper_q <= s_axi_wdata[7:0];
            `REG_RISE: rise_q <= s_axi_wdata[2:0];
            `REG_FALL: fall_q <= s_axi_wdata[2:0];
            `REG_OC_RESP: resp_q <= s_axi_wdata[1:0];
            `REG_OPTIONS: negdis_q <= s_axi_wdata[`OPT_NEGDIS_BIT];
            `REG_MASK: mask_q <= s_axi_wdata[0];
            default: ;
          endcase
        end
        if (s_axi_wstrb[0] && s_axi_wstrb[1]) begin
          case (s_axi_awaddr)
            `REG_TARGET: target_q <= s_axi_wdata[11:0];
            `REG_OC_FLT: ocf_q <= s_axi_wdata[11:0];
            `REG_OC_WRN: ocw_q <= s_axi_wdata[11:0];
            `REG_TRIM: trim_q <= s_axi_wdata[11:0];
            default: ;
          endcase
        end
      end
    end
  end
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else begin
      s_axi_arready <= s_axi_arvalid & ~s_axi_rvalid & ~s_axi_arready;
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= (s_axi_araddr <= `REG_MASK && s_axi_araddr[1:0] == 2'h0) ? 2'h0 : 2'h2;
        case (s_axi_araddr)
          `REG_CTRL: s_axi_rdata <= {31'h0, ctrl_q};
          `REG_OPER: s_axi_rdata <= {24'h0, oper_q};
          `REG_RISE: s_axi_rdata <= {29'h0, rise_q};
          `REG_FALL: s_axi_rdata <= {29'h0, fall_q};
          `REG_TARGET: s_axi_rdata <= {20'h0, target_q};
          `REG_OC_FLT: s_axi_rdata <= {20'h0, ocf_q};
          `REG_OC_WRN: s_axi_rdata <= {20'h0, ocw_q};
          `REG_OC_RESP: s_axi_rdata <= {30'h0, resp_q};
          `REG_TRIM: s_axi_rdata <= {20'h0, trim_q};
          `REG_OPTIONS: s_axi_rdata <= {31'h0, negdis_q};
          `REG_STATUS: s_axi_rdata <= {21'h0, state_q, 3'h0, sticky_q};
          `REG_IOUT: s_axi_rdata <= {20'h0, avg_q[14:3]};
          `REG_MASK: s_axi_rdata <= {31'h0, mask_q};
          default: s_axi_rdata <= 32'h00000000;
        endcase
      end
    end
  end
  // ----------------------------------------
  // Ramp timing
  // ----------------------------------------
  function [6:0] ms_of;
    input [2:0] sel;
    begin
      case (sel)
        3'd0: ms_of = 7'd1;
        3'd1: ms_of = 7'd2;
        3'd2: ms_of = 7'd5;
        3'd3: ms_of = 7'd10;
        3'd4: ms_of = 7'd20;
        3'd5: ms_of = 7'd50;
        default: ms_of = 7'd100;
      endcase
    end
  endfunction
  // The zero fall setting already maps to the fastest one millisecond stop.
  wire [31:0] rise_cyc = MS_CYCLES * ms_of(rise_q);
  wire [31:0] fall_cyc = MS_CYCLES * ms_of(fall_q);
  wire [31:0] hic_cyc = rise_cyc * `HICCUP_RISES;
  // ----------------------------------------
  // Sequencer and gate drive
  // ----------------------------------------
  reg [31:0] acc_q, hic_q;
  reg [9:0] cyc_q;
  reg [7:0] pb_q;
  reg [1:0] occ_q;
  reg pulses_q, hs_cut_q, neg_cut_q, skip_q, oc_seen_q, ocf_ev, ocw_ev;
  wire on_req = ctl_s & oper_q[`OPER_ON_BIT];
  wire flt = (state_q == S_HIC) || (state_q == S_LATCH) || ov_s;
  wire partner = ~share_s & ~shared_loop_line_oe;
  wire cyc_end = (cyc_q == LAST);
  wire hs_win = (cyc_q < duty_code);
  wire [9:0] lt = cyc_q - duty_code;
  wire [9:0] mid = duty_code + ((LAST - duty_code) >> 1);
  wire sw_en = ((state_q == S_SS && pulses_q) || state_q == S_RUN || state_q == S_STOP) && !flt && !partner;
  wire pb_ok = (pb_q == `PB_PULSES) || ({2'b00, lt[7:0]} < {2'b00, pb_q}) && (lt[9:8] == 2'b00);
  wire neg_on = !negdis_q && state_q != S_STOP;
  wire neg_end = (cyc_q >= PERIOD - MIN_OFF);
  wire neg_ok = !neg_on || neg_end || ((lt < MIN_OFF) ? !skip_q : (!neg_cut_q && !neg_s));
  wire hs_d = sw_en && hs_win && !hs_cut_q && !hsl_s;
  wire ls_d = ov_s || (sw_en && !hs_win && pb_ok && neg_ok);
  wire [12:0] samp_s = {1'b0, isense_code} + {trim_q[11], trim_q};
  wire [11:0] samp = samp_s[12] ? (trim_q[11] ? 12'h000 : 12'hFFF) : samp_s[11:0];
  wire [15:0] avg_next = {1'b0, avg_q} - {4'h0, avg_q[14:3]} + {4'h0, samp};
  assign ev = {neg_s & neg_on & ~hs_win, partner, ov_warning, ocw_ev, ocf_ev};
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= S_OFF;
      acc_q <= 32'h00000000;
      hic_q <= 32'h00000000;
      cyc_q <= 10'h000;
      pb_q <= 8'h00;
      occ_q <= 2'h0;
      pulses_q <= 1'b0;
      hs_cut_q <= 1'b0;
      neg_cut_q <= 1'b0;
      skip_q <= 1'b0;
      oc_seen_q <= 1'b0;
      ocf_ev <= 1'b0;
      ocw_ev <= 1'b0;
      avg_q <= 15'h0000;
      ref_code <= 12'h000;
      hs_gate <= 1'b0;
      ls_gate <= 1'b0;
      ov_warning <= 1'b0;
      alert_n <= 1'b1;
      shared_loop_line_o <= 1'b0;
      shared_loop_line_oe <= 1'b0;
    end else begin
      hs_gate <= hs_d;
      ls_gate <= ls_d;
      shared_loop_line_o <= 1'b0;
      shared_loop_line_oe <= flt;
      // Both products are formed at full integer width, so a high feedback code cannot wrap.
      ov_warning <= (feedback_input * `OVW_DEN > target_q * `OVW_NUM);
      alert_n <= ~(sticky_q[`ST_OCF_BIT] & ~mask_q);
      ocf_ev <= 1'b0;
      ocw_ev <= 1'b0;
      cyc_q <= cyc_end ? 10'h000 : cyc_q + 10'h001;
      if (hs_win && hsl_s) begin
        hs_cut_q <= 1'b1;
        oc_seen_q <= 1'b1;
      end
      if (!hs_win && neg_s && neg_on) begin
        neg_cut_q <= 1'b1;
      end
      if (neg_on && lt == MIN_OFF - 10'h001 && !hs_win) begin
        skip_q <= neg_s;
      end
      if (cyc_q == mid) begin
        avg_q <= avg_next[14:0];
        if (sw_en && samp > ocf_q) begin
          oc_seen_q <= 1'b1;
        end
        if (samp > ocw_q) begin
          ocw_ev <= 1'b1;
        end
      end
      if (cyc_end) begin
        hs_cut_q <= 1'b0;
        neg_cut_q <= 1'b0;
        oc_seen_q <= 1'b0;
        if (pulses_q && pb_q != `PB_PULSES) begin
          pb_q <= pb_q + 8'h01;
        end
        if (!sw_en || !oc_seen_q) begin
          occ_q <= 2'h0;
        end else if (occ_q == `OC_CONSEC - 1) begin
          occ_q <= 2'h0;
          ocf_ev <= 1'b1;
          if (resp_q == `RESP_LATCH) begin
            state_q <= S_LATCH;
          end else if (resp_q == `RESP_HICCUP) begin
            state_q <= S_HIC;
            hic_q <= 32'h00000000;
          end
          // Other policy codes flag the fault in ocf_ev but keep switching.
        end else begin
          occ_q <= occ_q + 2'h1;
        end
      end
      case (state_q)
        S_OFF: begin
          ref_code <= 12'h000;
          acc_q <= 32'h00000000;
          pulses_q <= 1'b0;
          pb_q <= 8'h00;
          if (on_req && !partner) begin
            state_q <= S_SS;
          end
        end
        S_SS: begin
          if (acc_q + target_q >= rise_cyc) begin
            acc_q <= acc_q + target_q - rise_cyc;
            if (ref_code != target_q) begin
              ref_code <= ref_code + 12'h001;
            end
          end else begin
            acc_q <= acc_q + target_q;
          end
          if (ref_code > feedback_input) begin
            pulses_q <= 1'b1;
          end
          if (ref_code == target_q) begin
            pulses_q <= 1'b1;
            state_q <= S_RUN;
          end
          if (!on_req) begin
            state_q <= ctrl_q ? S_STOP : S_OFF;
          end
        end
        S_RUN: begin
          acc_q <= 32'h00000000;
          if (!on_req) begin
            state_q <= ctrl_q ? S_STOP : S_OFF;
          end
        end
        S_STOP: begin
          if (ref_code == 12'h000) begin
            state_q <= S_OFF;
          end else if (acc_q + target_q >= fall_cyc) begin
            acc_q <= acc_q + target_q - fall_cyc;
            ref_code <= ref_code - 12'h001;
          end else begin
            acc_q <= acc_q + target_q;
          end
        end
        S_HIC: begin
          ref_code <= 12'h000;
          hic_q <= hic_q + 32'h00000001;
          if (hic_q >= hic_cyc - 32'h00000001) begin
            state_q <= S_OFF;
          end
        end
        S_LATCH: begin
          ref_code <= 12'h000;
          if (!on_req) begin
            state_q <= S_OFF;
          end
        end
        default: state_q <= S_OFF;
      endcase
    end
  end
endmodule // buck_seq

/* verification/partner_conv.sv */
// Behavioural model of the paralleled converter on the shared fault line.
`timescale 1ns/1ps
module partner_conv (
  input wire pull,
  input wire dut_oe,
  output wire line
);
  // ----
  // Shared line
  // ----
  // Open drain with a pull-up: either party pulling wins, and a released line reads high, never a stale value.
  assign line = !(pull || dut_oe);
endmodule // partner_conv

/* verification/buck_seq_props.sv */
// Concurrent checks on the ports of the buck sequencer.
`timescale 1ns/1ps
module buck_seq_props (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awvalid,
  input wire s_axi_wvalid,
  input wire s_axi_awready,
  input wire s_axi_bvalid,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire shared_loop_line_i,
  input wire shared_loop_line_oe,
  input wire hs_limit_cmp,
  input wire ov_cmp,
  input wire [11:0] ref_code,
  input wire hs_gate,
  input wire ls_gate
);
  // ----
  // Checks
  // ----
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  reset_quiet_a: assert property (disable iff (1'b0) !aresetn |=> !hs_gate && !ls_gate && ref_code == 12'h000)
    else $error("outputs active after reset");
  ref_step_a: assert property ($changed(ref_code) |-> ref_code == 12'h000 || ref_code == $past(ref_code) + 12'h001
    || ref_code == $past(ref_code) - 12'h001)
    else $error("reference jumped");
  gates_excl_a: assert property (!(hs_gate && ls_gate))
    else $error("both gates on");
  partner_stop_a: assert property ((!shared_loop_line_i && !shared_loop_line_oe && !ov_cmp) [*8] |-> !hs_gate && !ls_gate)
    else $error("switching while partner pulls line");
  hs_limit_a: assert property (hs_limit_cmp [*8] |-> !hs_gate)
    else $error("high side on past limit");
  ov_ls_a: assert property (ov_cmp [*8] |-> ls_gate && !hs_gate)
    else $error("low side not held on in overvoltage");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready |=> s_axi_awready && s_axi_bvalid)
    else $error("write not answered");
  rd_answer_a: assert property (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready |=> s_axi_arready && s_axi_rvalid)
    else $error("read not answered");
endmodule // buck_seq_props

/* verification/tb_buck_seq.sv */
// Self-checking bench for the buck sequencer.
`timescale 1ns/1ps
`include "buck_seq_defs.vh"
module tb_buck_seq;
  // Short counts keep the run small; the ramp and period expectations below are derived from them.
  localparam MS = 200;
  localparam PER = 100;
  localparam MIN_OFF = `MIN_OFF_NS * `CLK_MHZ / 1000;
  logic aclk, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic control = 1'b0, pull = 1'b0, hs_lim = 1'b0, neg_lim = 1'b0, ov = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rd;
  logic [11:0] fb = 12'h000, isense = 12'h100;
  logic [1:0] rsp;
  logic hs_seen, ref_nz;
  wire awready, wready, bvalid, arready, rvalid, line, oe, line_o, hs, ls, ovw, alert_n;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [11:0] ref_code;
  int mismatches = 0, samples_checked = 0, cyc = 0, i, n, ls_cnt;
  logic [7:0] ra [6] = '{`REG_CTRL, `REG_OPER, `REG_TARGET, `REG_OC_FLT, `REG_OC_WRN, `REG_OC_RESP};
  logic [31:0] rv [6] = '{32'h1, 32'h80, 32'h133, 32'hC00, 32'hA00, 32'h0};
  logic [31:0] st [3] = '{32'h501, 32'h401, 32'h201};
  buck_seq #(.MS_CYCLES(MS), .PERIOD(PER)) dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .control_pin(control), .shared_loop_line_i(line), .shared_loop_line_o(line_o), .shared_loop_line_oe(oe),
    .hs_limit_cmp(hs_lim), .neg_limit_cmp(neg_lim), .ov_cmp(ov), .feedback_input(fb), .isense_code(isense),
    .duty_code(10'h028), .ref_code(ref_code), .hs_gate(hs), .ls_gate(ls), .ov_warning(ovw), .alert_n(alert_n));
  partner_conv pc (.pull(pull), .dut_oe(oe), .line(line));
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      mismatches++;
      final_report();
    end
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    check("bresp", bresp, er);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    rd = rdata;
    rsp = rresp;
    check($sformatf("reg %h", a), rd & m, e);
  endtask
  task automatic watch(input int k);
    hs_seen = 1'b0;
    ref_nz = 1'b0;
    ls_cnt = 0;
    repeat (k) begin
      @(posedge aclk);
      hs_seen |= hs;
      ref_nz |= (ref_code != 12'h000);
      ls_cnt += ls;
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    for (i = 0; i < 6; i++) rchk(ra[i], 32'hFFF, rv[i]);
    rchk(8'h40, 32'hFFFFFFFF, 32'h0);
    check("rresp", rsp, 2'b10);
    wr(`REG_IOUT, 32'h5, 2'b10);
    $display("reset values done");
    wr(`REG_TARGET, 32'h40, 2'b00);
    fb <= 12'h020;
    control <= 1'b1;
    wr(`REG_OPER, 32'h40, 2'b00);
    n = 0;
    hs_seen = 1'b0;
    while (ref_code !== 12'h040 && n < 4 * MS) begin
      @(posedge aclk);
      n++;
      if (hs && ref_code <= fb) hs_seen = 1'b1;
    end
    check("prebias", hs_seen, 1'b0);
    check("ramp", n >= MS - 5 && n <= MS + 10, 1'b1);
    watch(PER);
    check("switching", hs_seen, 1'b1);
    check("ls narrow", ls_cnt < PER - 40, 1'b1);
    wr(`REG_TRIM, 32'h10, 2'b00);
    repeat (130 * PER) @(posedge aclk);
    watch(PER);
    check("ls full", ls_cnt, PER - 40);
    rchk(`REG_IOUT, 32'hFFFFF000, 32'h0);
    check("iout", rd >= 32'h109 && rd <= 32'h110, 1'b1);
    $display("start-up done");
    fb <= 12'h044;
    repeat (8) @(posedge aclk);
    check("ovw high", ovw, 1'b1);
    fb <= 12'h043;
    repeat (8) @(posedge aclk);
    check("ovw low", ovw, 1'b0);
    fb <= 12'h000;
    ov <= 1'b1;
    repeat (10) @(posedge aclk);
    check("ov ls", ls, 1'b1);
    ov <= 1'b0;
    $display("overvoltage done");
    neg_lim <= 1'b1;
    repeat (3 * PER) @(posedge aclk);
    watch(PER);
    check("neg clamp", ls_cnt, MIN_OFF);
    rchk(`REG_STATUS, 32'h10, 32'h10);
    wr(`REG_OPTIONS, 32'h1, 2'b00);
    repeat (2 * PER) @(posedge aclk);
    watch(PER);
    check("neg disabled", ls_cnt, PER - 40);
    wr(`REG_OPTIONS, 32'h0, 2'b00);
    neg_lim <= 1'b0;
    wr(`REG_OC_WRN, 32'h100, 2'b00);
    repeat (2 * PER) @(posedge aclk);
    rchk(`REG_STATUS, 32'h2, 32'h2);
    wr(`REG_OC_WRN, 32'hA00, 2'b00);
    // Short limit bursts split by a clean period must never add up to a fault.
    repeat (3) begin
      hs_lim <= 1'b1;
      repeat (150) @(posedge aclk);
      hs_lim <= 1'b0;
      repeat (2 * PER) @(posedge aclk);
    end
    rchk(`REG_STATUS, 32'h701, 32'h200);
    $display("negative limit and warning done");
    for (i = 0; i < 3; i++) begin
      wr(`REG_OC_RESP, i, 2'b00);
      wr(`REG_OPER, 32'h40, 2'b00);
      repeat (3 * MS) @(posedge aclk);
      hs_lim <= 1'b1;
      repeat (6 * PER) @(posedge aclk);
      rchk(`REG_STATUS, 32'h701, st[i]);
      check("alert", alert_n, 1'b0);
      if (i == 0) check("fault pull", oe, 1'b1);
      if (i == 1) watch(8 * MS);
      if (i == 1) check("retry", ref_nz, 1'b1);
      hs_lim <= 1'b0;
      wr(`REG_OPER, 32'h0, 2'b00);
      repeat (2 * MS) @(posedge aclk);
      wr(`REG_STATUS, 32'h1F, 2'b00);
      rchk(`REG_STATUS, 32'h1, 32'h0);
      check("alert clear", alert_n, 1'b1);
    end
    $display("overcurrent done");
    for (i = 0; i < 2; i++) begin
      wr(`REG_CTRL, i, 2'b00);
      wr(`REG_OPER, 32'h40, 2'b00);
      repeat (3 * MS) @(posedge aclk);
      wr(`REG_OPER, 32'h0, 2'b00);
      repeat (4) @(posedge aclk);
      if (i == 0) check("gates off", {hs, ls}, 2'b00);
      if (i == 1) check("soft stop", ref_code != 12'h000, 1'b1);
      repeat (MS + 20) @(posedge aclk);
      check("ref down", ref_code, 12'h000);
    end
    $display("turn-off done");
    wr(`REG_OPER, 32'h40, 2'b00);
    repeat (3 * MS) @(posedge aclk);
    pull <= 1'b1;
    repeat (12) @(posedge aclk);
    check("partner stop", {hs, ls}, 2'b00);
    rchk(`REG_STATUS, 32'h8, 32'h8);
    pull <= 1'b0;
    $display("shared line done");
    final_report();
  end
endmodule // tb_buck_seq
bind buck_seq buck_seq_props chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_wvalid, .s_axi_awready, .s_axi_bvalid,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .shared_loop_line_i, .shared_loop_line_oe, .hs_limit_cmp,
  .ov_cmp, .ref_code, .hs_gate, .ls_gate);
